/* File: pkg/ncf_pkg.sv */
// shared constants and types for the coprocessor control and fault block
// Operation
// - six exception masks in control bits 5-0
// - infinity bit 12 writable, affine always used
// - infinity bit cleared on reset and initialize
// - bits 11-10 select rounding mode
// - rounding applies only to rounding operations
// - bits 9-8 reduce precision below 64 bits
// - precision applies to add sub mul div sqrt
// - escape captures instruction, operand address, opcode
// - exceptions may be reported after instruction ends
// - operand pointer undefined without memory operand
// - pointer image layout follows real/protected mode
// - host raises 7 on emulate or task switch
// - host raises 9 on wrapped operand; the host end raises it only in protected mode
// - host raises 13; coprocessor skips, keeps pointers
// - 16 only on escape or wait forms
// - faulting pointers retained, instruction restartable
// - unmasked exception sets flag, summary, error
// - reset or initialize loads control word 037F
package ncf_pkg;
  localparam logic [15:0] CW_RESET = 16'h037F;
  localparam logic [15:0] CW_WMASK = 16'h1F3F;
  localparam logic [15:0] CW_FIXED = 16'h0040;
  localparam int CW_MASK_LSB = 0;
  localparam int CW_MASK_W = 6;
  localparam int CW_INF_BIT = 12;
  localparam int CW_RC_LSB = 10;
  localparam int CW_PC_LSB = 8;
  localparam logic [1:0] RC_NEAREST = 2'h0;
  localparam logic [1:0] PC_EXT = 2'h3;

  typedef enum logic [2:0] {
    K_ESC, K_WAIT, K_LDCW, K_LDENV, K_INIT, K_NINIT, K_NCLEX, K_NSTORE
  } ncf_kind_e;

  // operation classes as seen by the rounding and precision logic
  typedef enum logic [2:0] {
    C_BASIC, C_STORE, C_TRANS, C_ROUND, C_NOROUND, C_CTRL
  } ncf_cls_e;

  // host register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_IADDR = 8'h08;
  localparam logic [7:0] A_DADDR = 8'h0C;
  localparam logic [7:0] A_DATA = 8'h10;
  localparam logic [7:0] A_ISTAT = 8'h14;
  localparam logic [7:0] A_IMASK = 8'h18;
  localparam logic [7:0] A_DEVCW = 8'h1C;
  localparam logic [7:0] A_DEVIP = 8'h20;
  localparam logic [7:0] A_DEVDP = 8'h24;
  localparam logic [7:0] A_DEVST = 8'h28;

  // ctrl register bits
  localparam int CT_EM = 0;
  localparam int CT_TS = 1;
  localparam int CT_PROT = 2;
  localparam int CT_OVER = 3;
  localparam int CT_WRAP = 4;
  localparam int CT_MEM = 5;
  localparam int CT_W = 6;
  // cmd register fields
  localparam int CM_KIND_LSB = 0;
  localparam int CM_CLS_LSB = 3;
  localparam int CM_OPC_LSB = 16;
  // interrupt status bits
  localparam int IS_DONE = 0;
  localparam int IS_V7 = 1;
  localparam int IS_V9 = 2;
  localparam int IS_V13 = 3;
  localparam int IS_V16 = 4;
  localparam int IS_W = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic ncf_rounds(input ncf_cls_e c);
    return c inside {C_BASIC, C_STORE, C_TRANS, C_ROUND};
  endfunction : ncf_rounds

  function automatic logic ncf_precs(input ncf_cls_e c);
    return c == C_BASIC;
  endfunction : ncf_precs
endpackage : ncf_pkg

/* File: pkg/ncf_link_if.sv */
// link between the host cpu end and the coprocessor end
`timescale 1ns/1ps
interface ncf_link_if;
  logic req;
  ncf_pkg::ncf_kind_e kind;
  ncf_pkg::ncf_cls_e cls;
  logic [10:0] opcode;
  logic [31:0] iaddr;
  logic [31:0] daddr;
  logic has_mem;
  logic prot;
  logic [15:0] wdata;
  logic error_n;
  logic [15:0] cw;
  logic [31:0] ip_img;
  logic [31:0] dp_img;
  logic [7:0] stat;
  modport dev(input req, kind, cls, opcode, iaddr, daddr, has_mem, prot,
    wdata, output error_n, cw, ip_img, dp_img, stat);
  modport host(output req, kind, cls, opcode, iaddr, daddr, has_mem, prot,
    wdata, input error_n, cw, ip_img, dp_img, stat);
endinterface : ncf_link_if

/* File: verilog/ncf_ptr_reg.sv */
// one captured pointer with its mode-dependent memory image
`timescale 1ns/1ps
module ncf_ptr_reg (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cap,
  input wire logic [31:0] addr,
  input wire logic prot,
  input wire logic [10:0] tag,
  output logic [31:0] img_r
);
  logic [31:0] ptr_r;
  logic [19:0] lin;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ptr_r <= 32'h0000_0000;
    end else if (cap) begin
      ptr_r <= addr;
    end
  end

  // segment times sixteen plus offset gives the real-mode address
  assign lin = {ptr_r[31:16], 4'h0} + {4'h0, ptr_r[15:0]};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      img_r <= 32'h0000_0000;
    end else if (prot) begin
      img_r <= ptr_r;
    end else begin
      img_r <= {lin[19:16], 1'b0, tag, lin[15:0]};
    end
  end
endmodule : ncf_ptr_reg

/* File: verilog/ncf_dev_end.sv */
// coprocessor end: control word, exception flags, pointer capture
`timescale 1ns/1ps
module ncf_dev_end (
  input wire logic ref_clk,
  input wire logic rstn,
  ncf_link_if.dev lnk,
  input wire logic exc_valid,
  input wire logic [5:0] exc_flags,
  output logic round_apply_r,
  output logic [1:0] round_sel_r,
  output logic prec_apply_r,
  output logic [1:0] prec_sel_r,
  output logic affine_r,
  output logic [5:0] flags_r
);
  logic [15:0] cw_r;
  logic [10:0] opc_r;
  logic es_r;
  logic err_n_r;
  logic [7:0] stat_r;
  logic is_esc;
  logic is_init;
  logic is_clex;
  logic is_ldcw;
  logic is_ldenv;
  logic ip_cap;
  logic dp_cap;
  logic [5:0] flags_nxt;
  logic [5:0] mask;
  logic [15:0] cw_load;

  assign is_esc = lnk.req && lnk.kind == ncf_pkg::K_ESC;
  assign is_init = lnk.req && lnk.kind inside {ncf_pkg::K_INIT,
    ncf_pkg::K_NINIT};
  assign is_clex = lnk.req && lnk.kind == ncf_pkg::K_NCLEX;
  assign is_ldcw = lnk.req && lnk.kind == ncf_pkg::K_LDCW;
  assign is_ldenv = lnk.req && lnk.kind == ncf_pkg::K_LDENV;
  assign mask = cw_r[ncf_pkg::CW_MASK_LSB +: ncf_pkg::CW_MASK_W];

  // reserved bits are forced; bit 12 is stored and read back but drives no logic
  assign cw_load = (lnk.wdata & ncf_pkg::CW_WMASK) | ncf_pkg::CW_FIXED;

  // control word
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cw_r <= ncf_pkg::CW_RESET;
    end else if (is_init) begin
      cw_r <= ncf_pkg::CW_RESET;
    end else if (is_ldcw || is_ldenv) begin
      cw_r <= cw_load;
    end
  end

  // opcode capture; only forwarded escapes get here, so a skipped
  // or blocked instruction leaves the older pointers intact
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      opc_r <= 11'h000;
    end else if (is_esc || is_ldenv) begin
      opc_r <= lnk.opcode;
    end
  end

  assign ip_cap = is_esc || is_ldenv;
  // without a memory operand the data pointer simply keeps stale data
  assign dp_cap = (is_esc && lnk.has_mem) || is_ldenv;

  ncf_ptr_reg u_iptr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cap(ip_cap),
    .addr(lnk.iaddr),
    .prot(lnk.prot),
    .tag(opc_r),
    .img_r(lnk.ip_img)
  );

  ncf_ptr_reg u_dptr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cap(dp_cap),
    .addr(lnk.daddr),
    .prot(lnk.prot),
    .tag(11'h000),
    .img_r(lnk.dp_img)
  );

  // a new exception wins over a clear in the same cycle
  always_comb begin
    flags_nxt = (is_init || is_clex) ? 6'h00 : flags_r;
    if (exc_valid) begin
      flags_nxt = flags_nxt | exc_flags;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_r <= 6'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // summary follows flags and masks, so a reload re-derives it; the
  // datapath may flag long after the host has moved on
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      es_r <= 1'b0;
      err_n_r <= 1'b1;
    end else begin
      es_r <= |(flags_nxt & ~mask);
      err_n_r <= ~|(flags_nxt & ~mask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stat_r <= 8'h00;
    end else begin
      stat_r <= {~err_n_r, es_r, flags_r};
    end
  end

  // per-instruction mode selects, latched when the escape arrives
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      round_apply_r <= 1'b0;
      round_sel_r <= ncf_pkg::RC_NEAREST;
      prec_apply_r <= 1'b0;
      prec_sel_r <= ncf_pkg::PC_EXT;
    end else if (is_esc) begin
      round_apply_r <= ncf_pkg::ncf_rounds(lnk.cls);
      round_sel_r <= cw_r[ncf_pkg::CW_RC_LSB +: 2];
      prec_apply_r <= ncf_pkg::ncf_precs(lnk.cls);
      prec_sel_r <= ncf_pkg::ncf_precs(lnk.cls) ?
        cw_r[ncf_pkg::CW_PC_LSB +: 2] : ncf_pkg::PC_EXT;
    end
  end

  // projective closure is gone; the infinity bit has no effect
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      affine_r <= 1'b1;
    end else begin
      affine_r <= 1'b1;
    end
  end

  assign lnk.cw = cw_r;
  assign lnk.error_n = err_n_r;
  assign lnk.stat = stat_r;
endmodule : ncf_dev_end

/* File: verilog/ncf_host_end.sv */
// host cpu end: AXI4-Lite registers, fault vectoring, link driver
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ncf_host_end (
  input wire logic ref_clk,
  input wire logic rstn,
  ncf_link_if.host lnk,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic irq_r
);
  localparam int CT_W_L = ncf_pkg::CT_W;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [CT_W_L-1:0] ctrl_r;
  logic [31:0] iaddr_r;
  logic [31:0] daddr_r;
  logic [15:0] data_r;
  logic [4:0] istat_r;
  logic [4:0] imask_r;
  logic wr_fire;
  logic cmd_go;
  logic [31:0] cmdw;
  ncf_pkg::ncf_kind_e kind;
  logic esc_form;
  logic wait_form;
  logic v7;
  logic v13;
  logic v16;
  logic fwd;
  logic [4:0] ev;
  logic [4:0] istat_nxt;
  logic req_r;
  ncf_pkg::ncf_kind_e kind_r;
  ncf_pkg::ncf_cls_e cls_r;
  logic [10:0] opc_r;

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // write path: address and data taken in either order
  assign wr_fire = !s_awready && !s_wready && !s_bvalid;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= ncf_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= (awaddr_r <= ncf_pkg::A_IMASK && awaddr_r[1:0] == 2'h0)
          ? ncf_pkg::RESP_OKAY : ncf_pkg::RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_r <= '0;
      iaddr_r <= 32'h0000_0000;
      daddr_r <= 32'h0000_0000;
      data_r <= 16'h0000;
      imask_r <= 5'h00;
    end else if (wr_fire) begin
      unique case (awaddr_r)
        ncf_pkg::A_CTRL:
          ctrl_r <= CT_W_L'(merge(32'(ctrl_r), wdata_r, wstrb_r));
        ncf_pkg::A_IADDR: iaddr_r <= merge(iaddr_r, wdata_r, wstrb_r);
        ncf_pkg::A_DADDR: daddr_r <= merge(daddr_r, wdata_r, wstrb_r);
        ncf_pkg::A_DATA:
          data_r <= 16'(merge(32'(data_r), wdata_r, wstrb_r));
        ncf_pkg::A_IMASK:
          imask_r <= 5'(merge(32'(imask_r), wdata_r, wstrb_r));
        default: ;
      endcase
    end
  end

  // command decode and fault vectoring, done in the write cycle
  assign cmd_go = wr_fire && awaddr_r == ncf_pkg::A_CMD;
  assign cmdw = wdata_r;
  assign kind = ncf_pkg::ncf_kind_e'(cmdw[ncf_pkg::CM_KIND_LSB +: 3]);

  always_comb begin
    esc_form = kind != ncf_pkg::K_WAIT;
    wait_form = kind inside {ncf_pkg::K_ESC, ncf_pkg::K_WAIT,
      ncf_pkg::K_LDCW, ncf_pkg::K_LDENV, ncf_pkg::K_INIT};
    v7 = (esc_form && (ctrl_r[ncf_pkg::CT_EM] || ctrl_r[ncf_pkg::CT_TS]))
      || (kind == ncf_pkg::K_WAIT && ctrl_r[ncf_pkg::CT_TS]);
    v13 = !v7 && esc_form && ctrl_r[ncf_pkg::CT_PROT]
      && ctrl_r[ncf_pkg::CT_OVER];
    // nowait forms never see a pending error; blocked ones can rerun
    v16 = !v7 && !v13 && wait_form && !lnk.error_n;
    fwd = esc_form && !v7 && !v13 && !v16 && kind != ncf_pkg::K_NSTORE;
    ev = 5'h00;
    ev[ncf_pkg::IS_DONE] = cmd_go && !v7 && !v13 && !v16;
    ev[ncf_pkg::IS_V7] = cmd_go && v7;
    ev[ncf_pkg::IS_V9] = cmd_go && fwd && ctrl_r[ncf_pkg::CT_PROT]
      && ctrl_r[ncf_pkg::CT_WRAP];
    ev[ncf_pkg::IS_V13] = cmd_go && v13;
    ev[ncf_pkg::IS_V16] = cmd_go && v16;
  end

  // wrapped operand still executes; its pointers are not trusted
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      req_r <= 1'b0;
      kind_r <= ncf_pkg::K_NSTORE;
      cls_r <= ncf_pkg::C_CTRL;
      opc_r <= 11'h000;
    end else begin
      req_r <= cmd_go && fwd;
      if (cmd_go) begin
        kind_r <= kind;
        cls_r <= ncf_pkg::ncf_cls_e'(cmdw[ncf_pkg::CM_CLS_LSB +: 3]);
        opc_r <= cmdw[ncf_pkg::CM_OPC_LSB +: 11];
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    istat_nxt = istat_r;
    if (wr_fire && awaddr_r == ncf_pkg::A_ISTAT) begin
      istat_nxt = istat_r & ~(wdata_r[4:0] & {5{wstrb_r[0]}});
    end
    istat_nxt = istat_nxt | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      istat_r <= 5'h00;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  // read path
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= ncf_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= ncf_pkg::RESP_OKAY;
      unique case (s_araddr)
        ncf_pkg::A_CTRL: s_rdata <= 32'(ctrl_r);
        ncf_pkg::A_CMD: s_rdata <= 32'h0000_0000;
        ncf_pkg::A_IADDR: s_rdata <= iaddr_r;
        ncf_pkg::A_DADDR: s_rdata <= daddr_r;
        ncf_pkg::A_DATA: s_rdata <= 32'(data_r);
        ncf_pkg::A_ISTAT: s_rdata <= 32'(istat_r);
        ncf_pkg::A_IMASK: s_rdata <= 32'(imask_r);
        ncf_pkg::A_DEVCW: s_rdata <= 32'(lnk.cw);
        ncf_pkg::A_DEVIP: s_rdata <= lnk.ip_img;
        ncf_pkg::A_DEVDP: s_rdata <= lnk.dp_img;
        ncf_pkg::A_DEVST: s_rdata <= 32'(lnk.stat);
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= ncf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  assign lnk.req = req_r;
  assign lnk.kind = kind_r;
  assign lnk.cls = cls_r;
  assign lnk.opcode = opc_r;
  assign lnk.iaddr = iaddr_r;
  assign lnk.daddr = daddr_r;
  assign lnk.has_mem = ctrl_r[ncf_pkg::CT_MEM];
  assign lnk.prot = ctrl_r[ncf_pkg::CT_PROT];
  assign lnk.wdata = data_r;
endmodule : ncf_host_end

/* File: tb/ncf_chk.sv */
// assertions on the link between the host end and the coprocessor end
`timescale 1ns/1ps
module ncf_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req,
  input wire ncf_pkg::ncf_kind_e kind,
  input wire logic [10:0] opcode,
  input wire logic [31:0] iaddr,
  input wire logic [31:0] daddr,
  input wire logic has_mem,
  input wire logic prot,
  input wire logic [15:0] wdata,
  input wire logic error_n,
  input wire logic [15:0] cw,
  input wire logic [31:0] ip_img,
  input wire logic [31:0] dp_img,
  input wire logic [7:0] stat
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // real mode keeps only 20 bits of linear address; carry drops off
  function automatic logic [31:0] rimg(input logic [31:0] a,
      input logic [10:0] o);
    logic [19:0] l;
    l = {a[31:16], 4'h0} + {4'h0, a[15:0]};
    return {l[19:16], 1'b0, o, l[15:0]};
  endfunction : rimg
  property p_rst_val;
    $rose(rstn) |-> cw == ncf_pkg::CW_RESET && error_n && stat == 8'h00;
  endproperty
  property p_init_cw;
    req && kind inside {ncf_pkg::K_INIT, ncf_pkg::K_NINIT}
      |=> cw == ncf_pkg::CW_RESET;
  endproperty
  property p_ldcw;
    req && kind == ncf_pkg::K_LDCW |=>
      cw == (($past(wdata) & ncf_pkg::CW_WMASK) | ncf_pkg::CW_FIXED);
  endproperty
  property p_cw_fixed;
    cw[15:13] == 3'h0 && !cw[7] && cw[6];
  endproperty
  property p_summary;
    stat[7] == stat[6] && stat[6] == !$past(error_n)
      && stat[6] == |(stat[5:0] & ~$past(cw[5:0], 2));
  endproperty
  property p_no_fwd;
    req |-> !(kind inside {ncf_pkg::K_WAIT, ncf_pkg::K_NSTORE});
  endproperty
  property p_ip_cap;
    logic [31:0] a;
    logic [10:0] o;
    logic m;
    (req && kind == ncf_pkg::K_ESC, a = iaddr, o = opcode, m = prot)
      |-> ##3 ip_img == (m ? a : rimg(a, o));
  endproperty
  property p_dp_cap;
    logic [31:0] a;
    logic m;
    (req && kind == ncf_pkg::K_ESC && has_mem, a = daddr, m = prot)
      |-> ##3 dp_img == (m ? a : rimg(a, 11'h000));
  endproperty
  // images move only two cycles after a forwarded command or one cycle after a mode flip
  property p_ptr_hold;
    !$past(req, 2) && $past(prot) == $past(prot, 2)
      |-> $stable(ip_img) && $stable(dp_img);
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("control word or status wrong after reset");
  a_init_cw: assert property (p_init_cw)
    else $error("initialize did not reload control word");
  a_ldcw: assert property (p_ldcw)
    else $error("control word load value wrong");
  a_cw_fixed: assert property (p_cw_fixed)
    else $error("reserved control word bits wrong");
  a_summary: assert property (p_summary)
    else $error("summary or error output disagrees with flags and masks");
  a_no_fwd: assert property (p_no_fwd)
    else $error("wait or no-wait store forwarded");
  a_ip_cap: assert property (p_ip_cap)
    else $error("instruction pointer image wrong");
  a_dp_cap: assert property (p_dp_cap)
    else $error("operand pointer image wrong");
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer image changed without a command");
  c_esc: cover property (req && kind == ncf_pkg::K_ESC && prot);
  c_ldcw: cover property (req && kind == ncf_pkg::K_LDCW);
  c_err: cover property (!error_n);
endmodule : ncf_chk

/* File: tb/ncf_bench.sv */
// self-checking bench: host end and coprocessor end joined by the link
`timescale 1ns/1ps
module ncf_bench;
  logic ref_clk, rstn, exc_valid, irq_r;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, round_sel_r, prec_sel_r;
  logic [5:0] exc_flags, flags_r;
  logic round_apply_r, prec_apply_r, affine_r;
  logic [7:0] vc [6] = '{8'h01, 8'h02, 8'h01, 8'h0C, 8'h14, 8'h00};
  logic [2:0] vk [6] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h7};
  logic [7:0] ve [6] = '{8'h02, 8'h02, 8'h01, 8'h08, 8'h05, 8'h01};
  int n_fail, n_tests, cyc;
  ncf_link_if ncf_link_if_i();
  ncf_host_end ncf_host_end_i(.ref_clk, .rstn, .lnk(ncf_link_if_i),
    .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata,
    .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
    .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .irq_r);
  ncf_dev_end ncf_dev_end_i(.ref_clk, .rstn, .lnk(ncf_link_if_i),
    .exc_valid, .exc_flags, .round_apply_r, .round_sel_r, .prec_apply_r,
    .prec_sel_r, .affine_r, .flags_r);
  ncf_chk ncf_chk_i(.ref_clk, .rstn, .req(ncf_link_if_i.req),
    .kind(ncf_link_if_i.kind), .opcode(ncf_link_if_i.opcode),
    .iaddr(ncf_link_if_i.iaddr), .daddr(ncf_link_if_i.daddr),
    .has_mem(ncf_link_if_i.has_mem), .prot(ncf_link_if_i.prot),
    .wdata(ncf_link_if_i.wdata), .error_n(ncf_link_if_i.error_n),
    .cw(ncf_link_if_i.cw), .ip_img(ncf_link_if_i.ip_img),
    .dp_img(ncf_link_if_i.dp_img), .stat(ncf_link_if_i.stat));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // the whole run needs under a thousand cycles; this only cuts a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (!aw && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w && s_wready) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end while (!(aw && w && s_bvalid));
    s_bready <= 1'b0;
    chk(s_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ar;
    ar = 1'b0;
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (!ar && s_arready) begin
        ar = 1'b1;
        s_arvalid <= 1'b0;
      end
    end while (!(ar && s_rvalid));
    d = s_rdata;
    s_rready <= 1'b0;
    chk(s_rresp, er);
  endtask : rd
  task automatic rv(input logic [7:0] a, input logic [31:0] e);
    rd(a, ncf_pkg::RESP_OKAY);
    chk(d, e);
  endtask : rv
  // fixed settle: images land two edges after the write acts, inside the four waited
  task automatic cmd(input ncf_pkg::ncf_kind_e k,
      input ncf_pkg::ncf_cls_e c, input logic [10:0] op);
    wr(ncf_pkg::A_CMD, {5'h00, op, 10'h000, c, k}, ncf_pkg::RESP_OKAY);
    repeat (4) @(posedge ref_clk);
  endtask : cmd
  task automatic exc(input logic [5:0] f);
    @(posedge ref_clk);
    exc_valid <= 1'b1;
    exc_flags <= f;
    @(posedge ref_clk);
    exc_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : exc
  initial begin
    {rstn, exc_valid, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, exc_flags, s_awaddr, s_araddr, s_wdata} = '0;
    {n_fail, n_tests, cyc} = '0;
    s_wstrb = 4'hF;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rv(ncf_pkg::A_DEVCW, 32'h037F);
    rv(ncf_pkg::A_DEVST, 32'h0);
    chk({prec_sel_r, round_sel_r, affine_r}, 32'h19);
    rd(8'h2C, ncf_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(ncf_pkg::A_DEVCW, 32'h0, ncf_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ncf_pkg::A_DATA, 32'h3F | (i << 10) | (i << 8), ncf_pkg::RESP_OKAY);
      cmd(ncf_pkg::K_LDCW, ncf_pkg::C_CTRL, 11'h0);
      rv(ncf_pkg::A_DEVCW, 32'h7F | (i << 10) | (i << 8));
      for (int c = 0; c < 6; c++) begin
        cmd(ncf_pkg::K_ESC, ncf_pkg::ncf_cls_e'(c), 11'h0);
        chk({round_apply_r, prec_apply_r}, {c < 4, c == 0});
        chk(prec_sel_r, c == 0 ? i : 3);
        if (c < 4)
          chk(round_sel_r, i);
      end
    end
    for (int k = 0; k < 2; k++) begin
      wr(ncf_pkg::A_DATA, 32'hFFFF, ncf_pkg::RESP_OKAY);
      cmd(ncf_pkg::K_LDCW, ncf_pkg::C_CTRL, 11'h0);
      rv(ncf_pkg::A_DEVCW, 32'h1F7F);
      chk(affine_r, 1);
      cmd(k ? ncf_pkg::K_NINIT : ncf_pkg::K_INIT, ncf_pkg::C_CTRL, 11'h0);
      rv(ncf_pkg::A_DEVCW, 32'h037F);
    end
    $display("test control word done");
    wr(ncf_pkg::A_IADDR, 32'h1234_5678, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_DADDR, 32'h0123_4567, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_CTRL, 32'h20, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h5A5);
    rv(ncf_pkg::A_DEVIP, 32'h15A5_79B8);
    rv(ncf_pkg::A_DEVDP, 32'h0000_5797);
    wr(ncf_pkg::A_CTRL, 32'h24, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h5A5);
    rv(ncf_pkg::A_DEVIP, 32'h1234_5678);
    wr(ncf_pkg::A_CTRL, 32'h04, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_DADDR, 32'h0BAD_0000, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h5A5);
    rv(ncf_pkg::A_DEVDP, 32'h0123_4567);
    wr(ncf_pkg::A_DATA, 32'h0C7F, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_LDENV, ncf_pkg::C_CTRL, 11'h0);
    rv(ncf_pkg::A_DEVCW, 32'h0C7F);
    rv(ncf_pkg::A_DEVDP, 32'h0BAD_0000);
    $display("test pointers done");
    wr(ncf_pkg::A_CTRL, 32'h00, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_IMASK, 32'h1F, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_DATA, 32'h037E, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_LDCW, ncf_pkg::C_CTRL, 11'h0);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h5A5);
    exc(6'h02);
    rd(ncf_pkg::A_DEVST, ncf_pkg::RESP_OKAY);
    chk(d & 32'h7F, 32'h02);
    exc(6'h01);
    rd(ncf_pkg::A_DEVST, ncf_pkg::RESP_OKAY);
    chk(d & 32'h7F, 32'h43);
    chk({flags_r, ncf_link_if_i.error_n}, 32'h06);
    wr(ncf_pkg::A_ISTAT, 32'h1F, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_IADDR, 32'h5555_0000, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h7FF);
    rv(ncf_pkg::A_ISTAT, 32'h10);
    chk(irq_r, 1);
    rv(ncf_pkg::A_DEVIP, 32'h15A5_79B8);
    wr(ncf_pkg::A_IMASK, 32'h0, ncf_pkg::RESP_OKAY);
    wr(ncf_pkg::A_ISTAT, 32'h1F, ncf_pkg::RESP_OKAY);
    cmd(ncf_pkg::K_NSTORE, ncf_pkg::C_CTRL, 11'h0);
    rv(ncf_pkg::A_ISTAT, 32'h01);
    cmd(ncf_pkg::K_WAIT, ncf_pkg::C_CTRL, 11'h0);
    rv(ncf_pkg::A_ISTAT, 32'h11);
    chk(irq_r, 0);
    wr(ncf_pkg::A_IMASK, 32'h10, ncf_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(irq_r, 1);
    rv(ncf_pkg::A_IMASK, 32'h10);
    wr(ncf_pkg::A_ISTAT, 32'h1F, ncf_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(irq_r, 0);
    cmd(ncf_pkg::K_NCLEX, ncf_pkg::C_CTRL, 11'h0);
    rv(ncf_pkg::A_DEVST, 32'h0);
    cmd(ncf_pkg::K_ESC, ncf_pkg::C_BASIC, 11'h7FF);
    rv(ncf_pkg::A_ISTAT, 32'h01);
    $display("test exceptions done");
    for (int j = 0; j < 6; j++) begin
      wr(ncf_pkg::A_CTRL, vc[j], ncf_pkg::RESP_OKAY);
      wr(ncf_pkg::A_ISTAT, 32'h1F, ncf_pkg::RESP_OKAY);
      cmd(ncf_pkg::ncf_kind_e'(vk[j]), ncf_pkg::C_BASIC, 11'h0);
      rv(ncf_pkg::A_ISTAT, ve[j]);
    end
    $display("test vectors done");
    end_of_test();
  end
endmodule : ncf_bench
